// *** rtl/buffer_mode_pkg.sv ***
// Summary of operation
// - equal pointers with port B loaded last: remote flag at A, local flag at B
// - empty buffer with lockout enable holds receiving reader until first byte written
// - write via data-with-increment stores byte and advances the local pointer
// - reader catching writer: writer gets remote flag, reader local flag and lockout
// - writer a full buffer ahead: writer gets lockout and local flag, reader remote
// - full buffer blocks further writes from the sender until space is freed
// - mode pins: 00 reset, 11 standalone, 01 master, 10 slave
// - reset mode clears every control register bit
// - reset mode clears message-in flag and sets message-out flag
// - reset mode floats both data buses and both ready outputs
// - master ready is an unclocked active-high grant indication, no clock used
// - master and standalone arbitrate, slave does not; the master's decision is passed on to the others
// - slave lock input acts as access enable from the master's ready
// - slave never arbitrates; grants at once when enable goes high
// - slave ready release is synchronised to the sync clock as standalone
// - each data bus is eight bits, line 0 most significant, line 7 least
// - addressing data register drops ready; rises on clock edge after sampled grant
// - lock input counts only on RAM access; effective after remote cycle and lock end
// - lockout acknowledge sets when soft lock is effective, clears with soft lock
package buffer_mode_pkg;

  localparam int RAM_DEPTH = 256;

  // =====================================================================
  // mode pin decode, {mode_pin_one, mode_pin_two}
  typedef enum logic [1:0] {
    MODE_RESET = 2'b00,
    MODE_MASTER = 2'b01,
    MODE_SLAVE = 2'b10,
    MODE_STANDALONE = 2'b11
  } mode_e;

  // =====================================================================
  // host register select codes
  localparam logic [2:0] SEL_DATA_INC = 3'h0;
  localparam logic [2:0] SEL_POINTER = 3'h1;
  localparam logic [2:0] SEL_CONTROL = 3'h2;
  localparam logic [2:0] SEL_STATUS = 3'h3;
  localparam logic [2:0] SEL_DATA = 3'h4;
  localparam logic [2:0] SEL_MESSAGE = 3'h5;

  // control byte fields
  localparam int CTL_SOFT_LOCK = 0;
  localparam int CTL_LOCKOUT_EN = 1;
  // status byte fields
  localparam int ST_LOCKOUT_ACK = 0;
  localparam int ST_REMOTE_EQ = 1;
  localparam int ST_LOCAL_EQ = 2;
  localparam int ST_MSG_OUT = 3;
  localparam int ST_MSG_IN = 4;

  // =====================================================================
  // apb register byte addresses
  localparam logic [7:0] APB_POINTERS = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_CONTROL = 8'h08;
  localparam logic [1:0] MSG_OUT_RESET = 2'b11;

  // =====================================================================
  // one host port's pins, data line 0 is the msb
  typedef struct packed {
    logic cs_n;
    logic [2:0] register_select;
    logic we_n;
    logic oe_n;
    logic [0:7] data;
    logic lock_request_in;
    logic ready_sync_clock;
  } host_in_s;

  typedef struct packed {
    logic [0:7] data;
    logic data_oe;
    logic ready;
    logic ready_oe;
  } host_out_s;

  typedef struct packed {
    logic [RAM_DEPTH-1:0][7:0] ram;
    logic [1:0][7:0] ptr;
    logic last_loader;
    logic [1:0] equal_lockout_enable, soft_lock_bit, lockout_ack, lock_eff, mi, mo, grant, ready, smp;
    logic [1:0] clk_prev, we_prev, sel_prev, rd_prev;
    logic [1:0][2:0] rs_prev;
    logic [1:0][7:0] msg, rd_data;
  } state_s;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // =====================================================================
  // two stages; only the second stage reads the first
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // pin_sync
`default_nettype wire

// *** rtl/dual_port_buffer_mode_control.sv ***
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module dual_port_buffer_mode_control (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic mode_pin_one_i,
  input wire logic mode_pin_two_i,
  input wire buffer_mode_pkg::host_in_s [1:0] host_i,
  output buffer_mode_pkg::host_out_s [1:0] host_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import buffer_mode_pkg::*;

  localparam int SYNC_W = 2 * $bits(host_in_s) + 2;

  // =====================================================================
  // pin synchronisers
  logic [SYNC_W-1:0] sync_w;
  host_in_s [1:0] pin;
  mode_e mode;

  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({host_i, mode_pin_one_i, mode_pin_two_i}),
    .sync_o(sync_w)
  );

  assign pin = sync_w[SYNC_W-1:2];
  assign mode = mode_e'(sync_w[1:0]);

  state_s q;
  state_s d;
  logic ptr_equal;
  logic [1:0] local_ptr_equal;
  logic [1:0] remote_ptr_equal;
  logic [1:0][7:0] status;

  // =====================================================================
  // pointer equality names the last loaded port
  always_comb begin
    ptr_equal = (q.ptr[0] == q.ptr[1]);
    for (int p = 0; p < 2; p++) begin
      local_ptr_equal[p] = ptr_equal & (q.last_loader == p[0]);
      remote_ptr_equal[p] = ptr_equal & (q.last_loader != p[0]);
      status[p] = '0;
      status[p][ST_LOCKOUT_ACK] = q.lockout_ack[p];
      status[p][ST_REMOTE_EQ] = remote_ptr_equal[p];
      status[p][ST_LOCAL_EQ] = local_ptr_equal[p];
      status[p][ST_MSG_OUT] = q.mo[p];
      status[p][ST_MSG_IN] = q.mi[p];
    end
  end

  // =====================================================================
  // next state of both ports, ram and apb view
  always_comb begin
    logic [1:0] sel;
    logic [1:0] ram_sel;
    logic [1:0] wr_edge;
    logic [1:0] rd_end;
    logic [1:0] rd_msg;
    logic [1:0] wr_msg;
    logic [1:0] lock_req;
    logic [1:0] ptr_hold;
    logic other_busy;
    logic clk_rise;
    logic apb_wr;
    int o;
    sel = '0;
    ram_sel = '0;
    wr_edge = '0;
    rd_end = '0;
    rd_msg = '0;
    wr_msg = '0;
    lock_req = '0;
    ptr_hold = '0;
    other_busy = 1'b0;
    clk_rise = 1'b0;
    apb_wr = psel_i & penable_i & pwrite_i & (paddr_i == APB_CONTROL);
    o = 0;
    d = q;

    for (int p = 0; p < 2; p++) begin
      o = 1 - p;
      sel[p] = ~pin[p].cs_n;
      ram_sel[p] = sel[p] & (pin[p].register_select[1:0] == 2'b00);
      wr_edge[p] = sel[p] & pin[p].we_n & ~q.we_prev[p];
      rd_end[p] = q.sel_prev[p] & q.rd_prev[p] &
                  (~sel[p] | (pin[p].register_select != q.rs_prev[p]));
      // lock pin is active low and only counts on a ram access
      lock_req[p] = q.soft_lock_bit[p] | (~pin[p].lock_request_in & ram_sel[p]);
    end

    for (int p = 0; p < 2; p++) begin
      o = 1 - p;
      // lockout waits out the remote cycle and remote lockout
      if (!lock_req[p] || mode == MODE_SLAVE) begin
        d.lock_eff[p] = 1'b0;
      // port 1 sees port 0's fresh lockout, so two requests in one cycle cannot both win
      end else if (!((p == 0) ? q.lock_eff[1] : d.lock_eff[0]) && !q.grant[o]) begin
        d.lock_eff[p] = 1'b1;
      end
    end

    for (int p = 0; p < 2; p++) begin
      o = 1 - p;
      d.lockout_ack[p] = q.soft_lock_bit[p] & (q.lockout_ack[p] | d.lock_eff[p]);
      // port 1 sees port 0's fresh grant, so a tie goes to port 0
      other_busy = (p == 0) ? q.grant[1] : d.grant[0];
      if (mode == MODE_SLAVE) begin
        // no arbitration: enable from the master's ready grants at once
        d.grant[p] = ram_sel[p] & pin[p].lock_request_in;
      end else if (!ram_sel[p]) begin
        d.grant[p] = 1'b0;
      end else if (!q.grant[p] && !other_busy && !d.lock_eff[o] &&
                   !(local_ptr_equal[p] && q.equal_lockout_enable[p])) begin
        // local equal with lockout enable stalls empty reads and full writes
        d.grant[p] = 1'b1;
      end

      // sample grant while the sync clock is high, release on next rise
      clk_rise = pin[p].ready_sync_clock & ~q.clk_prev[p];
      if (mode == MODE_MASTER) begin
        // master ready follows the grant with no sync clock involved
        d.ready[p] = q.grant[p];
      end else if (!ram_sel[p]) begin
        d.smp[p] = 1'b0;
        d.ready[p] = 1'b0;
      end else begin
        if (clk_rise && q.smp[p]) begin
          d.ready[p] = 1'b1;
        end
        if (pin[p].ready_sync_clock) begin
          d.smp[p] = q.grant[p];
        end
      end

      // read data latched from the selected register
      case (pin[p].register_select)
        SEL_DATA_INC, SEL_DATA: d.rd_data[p] = q.ram[q.ptr[p]];
        SEL_POINTER: d.rd_data[p] = q.ptr[p];
        SEL_CONTROL: d.rd_data[p] = {6'h00, q.equal_lockout_enable[p], q.soft_lock_bit[p]};
        SEL_STATUS: d.rd_data[p] = status[p];
        SEL_MESSAGE: d.rd_data[p] = q.msg[p];
        default: d.rd_data[p] = 8'h00;
      endcase

      rd_msg[p] = rd_end[p] & (q.rs_prev[p] == SEL_MESSAGE);
      wr_msg[p] = wr_edge[p] & (pin[p].register_select == SEL_MESSAGE);
      d.clk_prev[p] = pin[p].ready_sync_clock;
      d.we_prev[p] = pin[p].we_n | ~sel[p];
      d.sel_prev[p] = sel[p];
      d.rd_prev[p] = sel[p] & ~pin[p].oe_n;
      d.rs_prev[p] = pin[p].register_select;
    end

    // pointer moves and ram writes, port 1 after port 0
    for (int p = 0; p < 2; p++) begin
      o = 1 - p;
      if (rd_end[p] && q.rs_prev[p] == SEL_DATA_INC && q.grant[p]) begin
        d.ptr[p] = q.ptr[p] + 8'h01;
        d.last_loader = p[0];
      end
      if (wr_edge[p]) begin
        case (pin[p].register_select)
          SEL_DATA_INC, SEL_DATA: begin
            // an ungranted write is dropped rather than corrupting ram
            if (q.grant[p]) begin
              d.ram[q.ptr[p]] = pin[p].data;
              if (pin[p].register_select == SEL_DATA_INC) begin
                d.ptr[p] = q.ptr[p] + 8'h01;
                d.last_loader = p[0];
              end
            end
          end
          SEL_POINTER: begin
            d.ptr[p] = pin[p].data;
            d.last_loader = p[0];
          end
          SEL_CONTROL: begin
            d.soft_lock_bit[p] = pin[p].data[7 - CTL_SOFT_LOCK];
            d.equal_lockout_enable[p] = pin[p].data[7 - CTL_LOCKOUT_EN];
          end
          SEL_MESSAGE: d.msg[o] = pin[p].data;
          default: ptr_hold[p] = 1'b1;
        endcase
      end
    end

    // message flags: a set beats a clear in the same cycle
    for (int p = 0; p < 2; p++) begin
      o = 1 - p;
      d.mi[p] = (q.mi[p] & ~rd_msg[p]) | wr_msg[o];
      d.mo[p] = (q.mo[p] & ~wr_msg[p]) | rd_msg[o];
    end

    // software view of the control bits
    if (apb_wr) begin
      d.soft_lock_bit = {pwdata_i[2], pwdata_i[0]};
      d.equal_lockout_enable = {pwdata_i[3], pwdata_i[1]};
    end

    // reset mode from the pins
    if (mode == MODE_RESET) begin
      d.soft_lock_bit = '0;
      d.equal_lockout_enable = '0;
      d.lockout_ack = '0;
      d.lock_eff = '0;
      d.grant = '0;
      d.ready = '0;
      d.mi = '0;
      d.mo = MSG_OUT_RESET;
    end

    if (reset_i) begin
      d = '0;
      d.mo = MSG_OUT_RESET;
      d.we_prev = 2'b11;
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // =====================================================================
  // host pins; outputs float in reset mode
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      host_o[p].data = q.rd_data[p];
      host_o[p].data_oe = (mode != MODE_RESET) & ~pin[p].cs_n & ~pin[p].oe_n;
      host_o[p].ready_oe = (mode != MODE_RESET);
      if (mode == MODE_MASTER) begin
        host_o[p].ready = q.grant[p];
      end else if (~pin[p].cs_n && pin[p].register_select[1:0] == 2'b00) begin
        host_o[p].ready = q.ready[p];
      end else begin
        host_o[p].ready = 1'b1;
      end
    end
  end

  // =====================================================================
  // apb slave, zero wait states
  always_comb begin
    prdata_o = 32'h0000_0000;
    pslverr_o = 1'b0;
    pready_o = 1'b1;
    if (paddr_i == APB_POINTERS) begin
      prdata_o = {16'h0000, q.ptr[1], q.ptr[0]};
    end else if (paddr_i == APB_STATUS) begin
      prdata_o = {10'h000, q.ready, q.grant, mode, status[1], status[0]};
    end else if (paddr_i == APB_CONTROL) begin
      prdata_o = {28'h000_0000, q.equal_lockout_enable[1], q.soft_lock_bit[1], q.equal_lockout_enable[0], q.soft_lock_bit[0]};
    end else begin
      pslverr_o = psel_i & penable_i;
    end
  end
endmodule // dual_port_buffer_mode_control
`default_nettype wire

// *** dv/buffer_mode_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// port watch: mode decode, apb answers, shared equal status
module buffer_mode_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic mode_pin_one_i,
  input wire logic mode_pin_two_i,
  input wire buffer_mode_pkg::host_out_s [1:0] host_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  import buffer_mode_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic acc, st_rd, ctl_rd, pins_low;
  // qualifiers for reads in the access phase
  assign acc = psel_i & penable_i;
  assign st_rd = acc & !pwrite_i & (paddr_i == APB_STATUS);
  assign ctl_rd = acc & !pwrite_i & (paddr_i == APB_CONTROL);
  assign pins_low = !mode_pin_one_i & !mode_pin_two_i;
  // pins need time through the synchroniser before the decode counts
  sequence s_pins_steady;
    $stable({mode_pin_one_i, mode_pin_two_i})[*4];
  endsequence
  sequence s_held_reset;
    pins_low[*4];
  endsequence
  a_zero_wait: assert property (acc |-> pready_o) else $error("access not answered");
  a_unmapped_error: assert property (acc && paddr_i > APB_CONTROL |-> pslverr_o)
    else $error("unmapped access without error");
  a_mode_decode: assert property (s_pins_steady ##0 st_rd |->
    prdata_o[17:16] == {mode_pin_one_i, mode_pin_two_i}) else $error("mode field wrong");
  a_control_cleared: assert property (s_held_reset ##0 ctl_rd |->
    prdata_o[3:0] == 4'h0) else $error("control kept in reset mode");
  a_message_flags: assert property (s_held_reset ##0 st_rd |->
    {prdata_o[12:11], prdata_o[4:3]} == 4'h5) else $error("message flags wrong");
  a_reset_floats: assert property (s_held_reset |->
    !(host_o[0].data_oe | host_o[0].ready_oe | host_o[1].data_oe | host_o[1].ready_oe))
    else $error("pins driven in reset mode");
  a_ready_driven: assert property (s_pins_steady ##0 !pins_low |->
    host_o[0].ready_oe && host_o[1].ready_oe) else $error("ready floats in run mode");
  a_master_ready: assert property (s_pins_steady ##0 st_rd && mode_pin_two_i
    && !mode_pin_one_i |-> {host_o[1].ready, host_o[0].ready} == prdata_o[19:18])
    else $error("ready not grant");
  a_one_grant: assert property (st_rd |-> !(prdata_o[18] && prdata_o[19]))
    else $error("both ports granted");
  a_equal_pairing: assert property (st_rd |-> prdata_o[1] == prdata_o[10]
    && prdata_o[2] == prdata_o[9] && !(prdata_o[1] && prdata_o[2]))
    else $error("equal flags disagree");
endmodule // buffer_mode_checker

bind dual_port_buffer_mode_control buffer_mode_checker i_checker (
  .clk_i(clk_i), .reset_i(reset_i), .mode_pin_one_i(mode_pin_one_i),
  .mode_pin_two_i(mode_pin_two_i), .host_o(host_o), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o)
);
`default_nettype wire

// *** dv/host_port_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// one host system: drives a port's pins, waits on ready for ram access
module host_port_model (
  input wire logic clk_i,
  output var buffer_mode_pkg::host_in_s pins_o,
  input wire buffer_mode_pkg::host_out_s pins_i
);
  import buffer_mode_pkg::*;
  int n = 0;
  initial pins_o = '{1'h1, 3'h0, 1'h1, 1'h1, 8'h00, 1'h1, 1'h0};
  // host clock runs free, slower than the core clock
  always @(posedge clk_i) begin
    n <= n + 1;
    pins_o.ready_sync_clock <= n[1];
  end
  // each phase lasts four edges so the pin synchroniser sees it
  task automatic set_pins(input logic cs_n, input logic we_n, input logic oe_n);
    @(posedge clk_i);
    pins_o.cs_n <= cs_n;
    pins_o.we_n <= we_n;
    pins_o.oe_n <= oe_n;
    repeat (3) @(posedge clk_i);
  endtask
  // lock pin, an access enable in slave mode
  task automatic lock(input logic v);
    @(posedge clk_i);
    pins_o.lock_request_in <= v;
  endtask
  // one register cycle; ok low when ready never came (host gives up)
  task automatic access(input logic [2:0] sel, input logic wr, input logic [0:7] wd,
                        output logic [0:7] rd, output logic ok);
    int k;
    @(posedge clk_i);
    pins_o.register_select <= sel;
    pins_o.data <= wd;
    set_pins(1'h0, 1'h1, wr);
    // one device per port here, so the and of all readies is this ready alone
    for (k = 0; k < 128 && sel[1:0] == 2'h0 && pins_i.ready !== 1'h1; k++) @(posedge clk_i);
    ok = (k < 128);
    set_pins(1'h0, !wr, wr);
    set_pins(1'h0, 1'h1, wr);
    rd = pins_i.data;
    set_pins(1'h1, 1'h1, 1'h1);
    pins_o.data <= ~wd; // released bus must not keep the last value
  endtask
endmodule // host_port_model
`default_nettype wire

// *** dv/dual_port_buffer_mode_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// bench: apb master, two host models, one task per scenario
module dual_port_buffer_mode_control_bench;
  import buffer_mode_pkg::*;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic mode_pin_one_i = 1'h1;
  logic mode_pin_two_i = 1'h1;
  wire host_in_s [1:0] host_i;
  host_out_s [1:0] host_o;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, ok, ok2, err;
  logic [0:7] b, b2;
  int fail_count = 0;
  int checks = 0;
  always #10 clk_i = ~clk_i;
  dual_port_buffer_mode_control i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .mode_pin_one_i(mode_pin_one_i), .mode_pin_two_i(mode_pin_two_i), .host_i(host_i),
    .host_o(host_o), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o));
  host_port_model i_host_a (.clk_i(clk_i), .pins_o(host_i[0]), .pins_i(host_o[0]));
  host_port_model i_host_b (.clk_i(clk_i), .pins_o(host_i[1]), .pins_i(host_o[1]));
  // =====================================================================
  // shared helpers
  task automatic wrap_up();
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'h1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk_i);
      if (pready_o === 1'h1) break;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    if (k == 16) begin
      fail_count++;
      wrap_up();
    end
    // idle edge so the next setup never reassigns psel in this time step
    @(posedge clk_i);
  endtask
  task automatic set_mode(input logic [1:0] m);
    mode_pin_one_i <= m[1];
    mode_pin_two_i <= m[0];
    repeat (6) @(posedge clk_i);
  endtask
  // =====================================================================
  // scenarios
  task automatic t_reset_mode();
    apb(1'h1, APB_CONTROL, 32'h0000_000f);
    set_mode(MODE_RESET);
    apb(1'h0, APB_CONTROL, 32'h0000_0000);
    check(32'(rd[3:0]), 32'h0000_0000);
    apb(1'h0, APB_STATUS, 32'h0000_0000);
    check(32'({rd[12:11], rd[4:3]}), 32'h0000_0005);
    check(32'({host_o[1].ready_oe, host_o[1].data_oe, host_o[0].ready_oe}), 32'h0000_0000);
  endtask
  // every code once, ending in standalone
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      set_mode(2'(m));
      apb(1'h0, APB_STATUS, 32'h0000_0000);
      check(32'(rd[17:16]), 32'(m));
      check(32'(host_o[0].ready_oe), 32'(m != 0));
    end
  endtask
  task automatic t_apb_map();
    apb(1'h1, APB_CONTROL, 32'h0000_000a);
    apb(1'h1, 8'h0c, 32'h0000_0005);
    check(32'(err), 32'h0000_0001);
    apb(1'h0, APB_CONTROL, 32'h0000_0000);
    check(32'(rd[3:0]), 32'h0000_000a);
    apb(1'h1, APB_CONTROL, 32'h0000_0008);
  endtask
  // empty buffer: reader b parks until writer a stores, then pointers wrap
  task automatic t_empty();
    i_host_a.access(SEL_POINTER, 1'h1, 8'hfe, b, ok);
    i_host_b.access(SEL_POINTER, 1'h1, 8'hfe, b, ok);
    apb(1'h0, APB_STATUS, 32'h0000_0000);
    check(32'({rd[9], rd[10], rd[1], rd[2]}), 32'h0000_0006);
    fork
      i_host_b.access(SEL_DATA_INC, 1'h0, 8'h00, b, ok);
      begin
        repeat (24) @(posedge clk_i);
        i_host_a.access(SEL_DATA_INC, 1'h1, 8'h5a, b2, ok2);
      end
    join
    check(32'({ok, b}), 32'h0000_015a);
    i_host_a.access(SEL_DATA_INC, 1'h1, 8'h3c, b2, ok2);
    i_host_b.access(SEL_DATA_INC, 1'h0, 8'h00, b, ok);
    check(32'(b), 32'h0000_003c);
    apb(1'h0, APB_POINTERS, 32'h0000_0000);
    check(32'(rd[15:0]), 32'h0000_0000);
    apb(1'h0, APB_STATUS, 32'h0000_0000);
    check(32'({rd[9], rd[10], rd[1], rd[2]}), 32'h0000_0006);
  endtask
  // writer a laps reader b, then is held off until b frees a byte
  task automatic t_full();
    apb(1'h1, APB_CONTROL, 32'h0000_000a);
    for (int i = 0; i < 256; i++) i_host_a.access(SEL_DATA_INC, 1'h1, 8'(i) ^ 8'ha5, b2, ok2);
    apb(1'h0, APB_STATUS, 32'h0000_0000);
    check(32'({rd[9], rd[10], rd[1], rd[2]}), 32'h0000_0009);
    i_host_a.access(SEL_DATA_INC, 1'h1, 8'hee, b2, ok2);
    check(32'(ok2), 32'h0000_0000);
    i_host_b.access(SEL_DATA_INC, 1'h0, 8'h00, b, ok);
    check(32'(b), 32'h0000_00a5);
    i_host_a.access(SEL_DATA_INC, 1'h1, 8'h11, b2, ok2);
    check(32'(ok2), 32'h0000_0001);
  endtask
  // receiver raises, then sender lowers, its pointer to be told at a chosen fill
  task automatic t_offsets();
    i_host_b.access(SEL_POINTER, 1'h1, 8'h03, b, ok);
    i_host_a.access(SEL_DATA_INC, 1'h1, 8'h21, b2, ok2);
    i_host_a.access(SEL_DATA_INC, 1'h1, 8'h22, b2, ok2);
    apb(1'h0, APB_STATUS, 32'h0000_0000);
    check(32'({rd[9], rd[10], rd[1], rd[2]}), 32'h0000_0009);
    i_host_a.access(SEL_POINTER, 1'h1, 8'h04, b2, ok2);
    i_host_b.access(SEL_DATA_INC, 1'h0, 8'h00, b, ok);
    apb(1'h0, APB_STATUS, 32'h0000_0000);
    check(32'({rd[9], rd[10], rd[1], rd[2]}), 32'h0000_0006);
    i_host_a.access(SEL_POINTER, 1'h1, 8'h03, b2, ok2);
    apb(1'h0, APB_POINTERS, 32'h0000_0000);
    check(32'(rd[15:0]), 32'h0000_0403);
  endtask
  task automatic t_master();
    set_mode(MODE_MASTER);
    fork
      i_host_a.access(SEL_DATA, 1'h0, 8'h00, b, ok);
      begin
        repeat (8) @(posedge clk_i);
        apb(1'h0, APB_STATUS, 32'h0000_0000);
      end
    join
    check(32'({ok, rd[21:18]}), 32'h0000_0015);
  endtask
  // slave: no enable, no access; enable high grants at once
  task automatic t_slave();
    set_mode(MODE_SLAVE);
    i_host_a.lock(1'h0);
    i_host_a.access(SEL_DATA, 1'h0, 8'h00, b, ok);
    check(32'(ok), 32'h0000_0000);
    i_host_a.lock(1'h1);
    i_host_a.access(SEL_DATA, 1'h0, 8'h00, b, ok);
    check(32'(ok), 32'h0000_0001);
  endtask
  // =====================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    t_reset_mode();
    t_modes();
    t_apb_map();
    t_empty();
    t_full();
    t_offsets();
    t_master();
    t_slave();
    wrap_up();
  end
endmodule // dual_port_buffer_mode_control_bench
`default_nettype wire
